// ### shared/fsp_consts.svh
// Purpose: named offsets, field positions, values and codes for the nv security block
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FSP_OFF_OPT 8'h00
`define FSP_OFF_CFG 8'h04
`define FSP_OFF_PROT 8'h08
`define FSP_OFF_STAT 8'h0c
`define FSP_OFF_DIV 8'h10
`define FSP_OFF_CMD 8'h14
// ----------------------------------------
// field positions and values
// ----------------------------------------
`define FSP_OPT_BACKDOOR_ENABLE 7
`define FSP_OPT_NORED 6
`define FSP_SEC_UNSEC 2'h2
`define FSP_CFG_KEYSEL 5
`define FSP_PROT_OFF 0
`define FSP_ST_EMPTY 7
`define FSP_ST_DONE 6
`define FSP_ST_PVIOL 5
`define FSP_ST_ACCERR 4
`define FSP_ST_BLANK 2
`define FSP_DIV_LD 7
`define FSP_PAGE_ONES 9'h1ff
`define FSP_KEY_BASE 16'hffb0
`define FSP_KEY_LAST 16'hffb7
`define FSP_KEY_BYTES 4'h8
// ----------------------------------------
// command codes
// ----------------------------------------
`define FSP_CMD_BLANK 8'h05
`define FSP_CMD_PROG 8'h20
`define FSP_CMD_BURST 8'h25
`define FSP_CMD_PAGE 8'h40
`define FSP_CMD_MASS 8'h41
`endif

// ### shared/fsp_pkg.sv
// Purpose: types shared by the nv security block
// Assumes: one bus clock
// Notes: constants live in fsp_consts.svh
package fsp_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } fsp_apb_req_s;
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } fsp_arr_wr_s;
  typedef struct packed {
    logic taken;
    logic done;
    logic blank_ok;
  } fsp_eng_s;
  typedef struct packed {
    logic launch;
    logic [7:0] code;
    logic [15:0] addr;
    logic [7:0] data;
  } fsp_cmd_s;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_DATA = 3'h2,
    SEQ_CMD = 3'h4
  } fsp_seq_e;
endpackage

// ### core/fsp_prot_check.sv
// Purpose: decides whether a command hits a protected location
// Assumes: 16-bit array addresses, 512-byte blocks
// Notes: purely combinational
`timescale 1ns/100ps
`include "fsp_consts.svh"
module fsp_prot_check (
  input wire logic [7:0] prot,
  input wire logic [7:0] code,
  input wire logic [15:0] addr,
  output logic hit
);
  logic [15:0] free_end;
  always_comb begin
    free_end = {prot[7:1], `FSP_PAGE_ONES};
    hit = 1'b0;
    if (!prot[`FSP_PROT_OFF]) begin // RULE14
      if (code == `FSP_CMD_MASS) begin
        hit = 1'b1;
      end else if (code != `FSP_CMD_BLANK) begin
        hit = (addr > free_end); // RULE13
      end
    end
  end
endmodule

// ### core/fsp_key_match.sv
// Purpose: collects an in-order 8-byte key and compares it to the stored key
// Assumes: byte i of the key sits at stored_key[8*i +: 8]
// Notes: any out-of-order byte spoils the attempt until restart
`timescale 1ns/100ps
`include "fsp_consts.svh"
module fsp_key_match (
  input wire logic clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic wr,
  input wire logic [2:0] idx,
  input wire logic [7:0] data,
  input wire logic [63:0] stored_key,
  output logic match
);
  logic [3:0] cnt_q;
  logic ok_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      ok_q <= 1'b1;
    end else if (restart) begin
      cnt_q <= 4'h0;
      ok_q <= 1'b1;
    end else if (wr) begin
      // order matters: a skipped byte must never count
      if (cnt_q == `FSP_KEY_BYTES || {1'b0, idx} != cnt_q ||
          stored_key[{idx, 3'h0} +: 8] != data) begin // RULE5
        ok_q <= 1'b0;
      end
      if (cnt_q != `FSP_KEY_BYTES) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
  assign match = ok_q && (cnt_q == `FSP_KEY_BYTES);
  // a wrong byte must spoil the attempt, even as the eighth one
  key_spoil_a: assert property (@(posedge clk) disable iff (rst) // RULE5
    wr && !restart && stored_key[{idx, 3'h0} +: 8] != data |=> !match)
    else $error("wrong key byte still matched");
endmodule

// ### core/fsp_core.sv
// Purpose: option, config, protection and status registers of the nv controller
// Assumes: apb slave on clk; stored bytes valid from reset release
// Notes: sequencing engine sits outside and reports through eng
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/100ps
`include "fsp_consts.svh"
// Behaviour
// RULE1 - option shadow reloaded from storage every reset
// RULE2 - software reprograms storage then resets
// RULE3 - option bit 7 zero blocks key release
// RULE4 - key bytes from debug are ignored
// RULE5 - matching ordered 8-byte key releases security
// RULE6 - option bit 6 set disables vector redirection
// RULE7 - only security code 1:0 is unsecured
// RULE8 - secure part refuses unsecured memory access
// RULE9 - key match or blank pass sets code 1:0
// RULE10 - config bit 5 routes key window writes
// RULE11 - protection shadow reloaded from storage every reset
// RULE12 - app writes only enlarge protection, or none
// RULE13 - bits 7:1 bound unprotected region, block protected
// RULE14 - protection bit 0 set protects nothing
// RULE15 - debug writes may change protection freely
// RULE16 - writing 1 launches and clears buffer empty
// RULE17 - only burst commands wait in the buffer; the code lets any legal command code wait alike
// RULE18 - complete set when idle, cleared on launch
// RULE19 - protected target sets violation, write 1 clears
// RULE20 - sequence, divider or stop fault sets access error
// RULE21 - blank flag set by passing check, cleared on launch
// RULE22 - unknown command codes raise access error
// RULE23 - key compared when key select returns to 0
// RULE24 - divider loaded on first write, gates commands
// RULE25 - flags synchronous, shadows reloaded after reset
module fsp_core (
  input wire logic clk,
  input wire logic rst,
  input wire fsp_pkg::fsp_apb_req_s apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] stored_option_byte,
  input wire logic [7:0] stored_protect_byte,
  input wire logic [63:0] stored_unlock_key,
  input wire logic background_debug_mode,
  input wire logic stop_entry,
  input wire fsp_pkg::fsp_arr_wr_s arr_wr,
  input wire fsp_pkg::fsp_eng_s eng,
  output fsp_pkg::fsp_cmd_s cmd,
  output logic cmd_abort,
  output logic backdoor_enable,
  output logic vector_redirect_disable,
  output logic secure,
  output logic [7:0] protect_shadow,
  output logic [6:0] nv_clock_divider
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic legal_cmd(input logic [7:0] c);
    legal_cmd = (c == `FSP_CMD_BLANK) || (c == `FSP_CMD_PROG) || (c == `FSP_CMD_BURST) ||
                (c == `FSP_CMD_PAGE) || (c == `FSP_CMD_MASS);
  endfunction

  logic load_q;
  logic [7:0] opt_q;
  logic [1:0] sec_q;
  logic keysel_q;
  logic [7:0] prot_q;
  logic [6:0] div_q;
  logic div_ld_q;
  logic empty_q;
  logic done_q;
  logic pviol_q;
  logic accerr_q;
  logic blank_q;
  logic [1:0] pend_q;
  logic [7:0] code_q;
  logic [15:0] addr_q;
  logic [7:0] data_q;
  fsp_pkg::fsp_seq_e seq_q;
  logic [31:0] rd_q;
  logic abort_q;
  logic launch_q;

  logic acc;
  logic wr;
  logic mapped;
  logic [31:0] rdata;
  logic key_win;
  logic key_wr;
  logic cmd_arr_wr;
  logic cmd_reg_wr;
  logic try_launch;
  logic launch_ok;
  logic prot_hit;
  logic seq_err;
  logic key_match;
  logic key_release;
  logic stop_err;
  logic cfg_wr;
  logic prot_wr;

  assign acc = apb.psel && apb.penable && pready;
  assign wr = acc && apb.pwrite;
  assign cfg_wr = wr && apb.paddr == `FSP_OFF_CFG;
  assign prot_wr = wr && apb.paddr == `FSP_OFF_PROT;
  assign cmd_reg_wr = wr && apb.paddr == `FSP_OFF_CMD;
  assign key_win = arr_wr.addr >= `FSP_KEY_BASE && arr_wr.addr <= `FSP_KEY_LAST;
  assign key_wr = arr_wr.valid && keysel_q && key_win && !background_debug_mode; // RULE10 RULE4
  assign cmd_arr_wr = arr_wr.valid && !(keysel_q && key_win); // RULE10
  assign try_launch = wr && apb.paddr == `FSP_OFF_STAT && apb.pwdata[`FSP_ST_EMPTY] &&
                      empty_q; // RULE16
  assign seq_err = seq_q != fsp_pkg::SEQ_CMD;
  assign launch_ok = try_launch && !seq_err && div_ld_q && legal_cmd(code_q) &&
                     !prot_hit; // RULE20 RULE24 RULE22 RULE19
  assign stop_err = stop_entry && pend_q != 2'h0; // RULE20
  assign key_release = cfg_wr && keysel_q && !apb.pwdata[`FSP_CFG_KEYSEL] &&
                       opt_q[`FSP_OPT_BACKDOOR_ENABLE] && key_match; // RULE23 RULE3

  fsp_prot_check u_prot (
    .prot(prot_q),
    .code(code_q),
    .addr(addr_q),
    .hit(prot_hit)
  );

  fsp_key_match u_key (
    .clk(clk),
    .rst(rst),
    .restart(cfg_wr && apb.pwdata[`FSP_CFG_KEYSEL] && !keysel_q),
    .wr(key_wr),
    .idx(arr_wr.addr[2:0]),
    .data(arr_wr.data),
    .stored_key(stored_unlock_key),
    .match(key_match)
  );

  // ----------------------------------------
  // shadow load after reset
  // ----------------------------------------
  // stored bytes are sampled one edge after release, never under reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_q <= 1'b1;
    end else begin
      load_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opt_q <= 8'h00;
    end else if (load_q) begin
      opt_q <= stored_option_byte; // RULE1 RULE25
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_q <= 2'h0;
    end else if (load_q) begin
      sec_q <= stored_option_byte[1:0]; // RULE1
    end else if (key_release || eng.blank_ok) begin
      sec_q <= `FSP_SEC_UNSEC; // RULE9 RULE5
    end
  end

  // ----------------------------------------
  // config and protection
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      keysel_q <= 1'b0;
    end else if (cfg_wr) begin
      keysel_q <= apb.pwdata[`FSP_CFG_KEYSEL]; // RULE10
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prot_q <= 8'h00;
    end else if (load_q) begin
      prot_q <= stored_protect_byte; // RULE11
    end else if (prot_wr) begin
      if (background_debug_mode) begin
        prot_q <= apb.pwdata[7:0]; // RULE15
      end else if (!prot_q[`FSP_PROT_OFF] && apb.pwdata[7:1] < prot_q[7:1]) begin
        prot_q[7:1] <= apb.pwdata[7:1]; // RULE12
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 7'h00;
      div_ld_q <= 1'b0;
    end else if (wr && apb.paddr == `FSP_OFF_DIV && !div_ld_q) begin
      div_q <= apb.pwdata[6:0];
      div_ld_q <= 1'b1; // RULE24
    end
  end

  // ----------------------------------------
  // command sequence
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_q <= fsp_pkg::SEQ_IDLE;
      addr_q <= 16'h0000;
      data_q <= 8'h00;
      code_q <= 8'h00;
    end else if (try_launch || stop_err) begin
      seq_q <= fsp_pkg::SEQ_IDLE;
    end else if (cmd_arr_wr) begin
      addr_q <= arr_wr.addr;
      data_q <= arr_wr.data;
      seq_q <= (seq_q == fsp_pkg::SEQ_IDLE && empty_q) ? fsp_pkg::SEQ_DATA :
               fsp_pkg::SEQ_IDLE;
    end else if (cmd_reg_wr) begin
      code_q <= apb.pwdata[7:0];
      seq_q <= (seq_q == fsp_pkg::SEQ_DATA) ? fsp_pkg::SEQ_CMD : fsp_pkg::SEQ_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      launch_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      launch_q <= launch_ok;
      abort_q <= stop_err;
    end
  end

  // any command code allows one command running plus one waiting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q <= 2'h0;
    end else if (stop_err) begin
      pend_q <= 2'h0;
    end else if (launch_ok && !eng.done) begin
      pend_q <= pend_q + 2'h1;
    end else if (eng.done && !launch_ok && pend_q != 2'h0) begin
      pend_q <= pend_q - 2'h1;
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      empty_q <= 1'b1;
    end else if (launch_ok) begin
      empty_q <= 1'b0; // RULE16
    end else if (eng.taken || stop_err) begin
      empty_q <= 1'b1; // RULE17
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b1;
    end else if (launch_ok) begin
      done_q <= 1'b0; // RULE18
    end else begin
      done_q <= empty_q && (pend_q == 2'h0 || (pend_q == 2'h1 && eng.done)); // RULE18
    end
  end

  // a set in the same cycle as a write-1 clear wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pviol_q <= 1'b0;
    end else if (try_launch && prot_hit && !seq_err) begin
      pviol_q <= 1'b1; // RULE19
    end else if (wr && apb.paddr == `FSP_OFF_STAT && apb.pwdata[`FSP_ST_PVIOL]) begin
      pviol_q <= 1'b0; // RULE19
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accerr_q <= 1'b0;
    end else if ((try_launch && (seq_err || !div_ld_q || !legal_cmd(code_q))) ||
                 (cmd_arr_wr && (seq_q != fsp_pkg::SEQ_IDLE || !empty_q)) ||
                 (cmd_reg_wr && seq_q != fsp_pkg::SEQ_DATA) || stop_err) begin
      accerr_q <= 1'b1; // RULE20 RULE22 RULE24
    end else if (wr && apb.paddr == `FSP_OFF_STAT && apb.pwdata[`FSP_ST_ACCERR]) begin
      accerr_q <= 1'b0; // RULE20
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blank_q <= 1'b0;
    end else if (eng.blank_ok) begin
      blank_q <= 1'b1; // RULE21
    end else if (launch_ok) begin
      blank_q <= 1'b0; // RULE21
    end
  end

  // ----------------------------------------
  // apb read side
  // ----------------------------------------
  always_comb begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    unique case (apb.paddr)
      `FSP_OFF_OPT: rdata[7:0] = {opt_q[7:2], sec_q};
      `FSP_OFF_CFG: rdata[`FSP_CFG_KEYSEL] = keysel_q;
      `FSP_OFF_PROT: rdata[7:0] = prot_q;
      `FSP_OFF_STAT: begin
        rdata[`FSP_ST_EMPTY] = empty_q;
        rdata[`FSP_ST_DONE] = done_q;
        rdata[`FSP_ST_PVIOL] = pviol_q;
        rdata[`FSP_ST_ACCERR] = accerr_q;
        rdata[`FSP_ST_BLANK] = blank_q;
      end
      `FSP_OFF_DIV: rdata[7:0] = {div_ld_q, div_q};
      `FSP_OFF_CMD: rdata[7:0] = code_q;
      default: mapped = 1'b0;
    endcase
  end

  // read data captured in the setup cycle, so no wait state is needed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_q <= 32'h0000_0000;
    end else if (apb.psel && !apb.penable) begin
      rd_q <= rdata;
    end
  end

  assign prdata = rd_q;
  assign pready = !load_q;
  assign pslverr = apb.psel && apb.penable && !mapped;

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign cmd.launch = launch_q;
  assign cmd.code = code_q;
  assign cmd.addr = addr_q;
  assign cmd.data = data_q;
  assign cmd_abort = abort_q;
  assign backdoor_enable = opt_q[`FSP_OPT_BACKDOOR_ENABLE];
  assign vector_redirect_disable = opt_q[`FSP_OPT_NORED]; // RULE6
  assign secure = sec_q != `FSP_SEC_UNSEC; // RULE7 RULE8
  assign protect_shadow = prot_q;
  assign nv_clock_divider = div_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  opt_reload_a: assert property (@(posedge clk) disable iff (rst) // RULE1
    $fell(load_q) |-> opt_q == $past(stored_option_byte)) else $error("option not reloaded");
  prot_reload_a: assert property (@(posedge clk) disable iff (rst) // RULE11
    $fell(load_q) |-> prot_q == $past(stored_protect_byte)) else $error("protect not reloaded");
  key_gate_a: assert property (@(posedge clk) disable iff (rst) $fell(secure) && // RULE3
    !$past(load_q) |-> $past(eng.blank_ok || opt_q[`FSP_OPT_BACKDOOR_ENABLE])) else $error("key release");
  debug_key_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    arr_wr.valid && background_debug_mode |-> !key_wr) else $error("debug key byte taken");
  unsec_code_a: assert property (@(posedge clk) disable iff (rst) // RULE9
    key_release || eng.blank_ok |=> !secure ##1 !secure) else $error("security not released");
  prot_grow_a: assert property (@(posedge clk) disable iff (rst) // RULE12
    prot_wr && !background_debug_mode && !load_q |=> prot_q[7:1] <= $past(prot_q[7:1]) &&
    prot_q[0] == $past(prot_q[0])) else $error("app write shrank protection");
  launch_clear_a: assert property (@(posedge clk) disable iff (rst) // RULE16
    launch_ok |=> !empty_q && !done_q && cmd.launch) else $error("launch flags wrong");
  pviol_set_a: assert property (@(posedge clk) disable iff (rst) // RULE19
    try_launch && prot_hit && !seq_err |=> pviol_q && !cmd.launch) else $error("pviol missed");
  div_gate_a: assert property (@(posedge clk) disable iff (rst) // RULE24
    try_launch && !div_ld_q |=> accerr_q && !cmd.launch) else $error("launch before divider");
  bad_code_a: assert property (@(posedge clk) disable iff (rst) // RULE22
    try_launch && !legal_cmd(code_q) |=> accerr_q && empty_q) else $error("illegal code taken");
  blank_flag_a: assert property (@(posedge clk) disable iff (rst) // RULE21
    eng.blank_ok |=> blank_q) else $error("blank flag not set");
endmodule

// ### verif/fsp_core_bench.sv
// Purpose: self-checking bench for the nv option, protection and status registers
// Assumes: zero-wait apb after the post-reset load cycle, engine played by the bench
// Notes: stored bytes are changed around resets, and once without a reset to check that the option shadow keeps its value
`timescale 1ns/100ps
`include "fsp_consts.svh"
module fsp_core_bench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  fsp_pkg::fsp_apb_req_s apb = '0;
  fsp_pkg::fsp_arr_wr_s arr_wr = '0;
  fsp_pkg::fsp_eng_s eng = '0;
  fsp_pkg::fsp_cmd_s cmd;
  logic [31:0] prdata;
  logic pready, pslverr, cmd_abort, backdoor_enable, vector_redirect_disable, secure;
  logic [7:0] stored_option_byte = 8'h03;
  logic [7:0] stored_protect_byte = 8'hff;
  logic [63:0] stored_unlock_key = 64'h8877665544332211;
  logic background_debug_mode = 1'b0;
  logic stop_entry = 1'b0;
  logic [7:0] protect_shadow;
  logic [6:0] nv_clock_divider;
  logic lerr;
  logic [7:0] last_code = 8'h00;
  int failures = 0;
  int checked = 0;
  int launches = 0;
  int aborts = 0;
  int exp_l = 0;
  always #25 clk = ~clk;
  fsp_core u_fsp_core (
    .clk(clk), .rst(rst), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stored_option_byte(stored_option_byte), .stored_protect_byte(stored_protect_byte),
    .stored_unlock_key(stored_unlock_key), .background_debug_mode(background_debug_mode),
    .stop_entry(stop_entry), .arr_wr(arr_wr), .eng(eng), .cmd(cmd), .cmd_abort(cmd_abort),
    .backdoor_enable(backdoor_enable), .vector_redirect_disable(vector_redirect_disable),
    .secure(secure), .protect_shadow(protect_shadow), .nv_clock_divider(nv_clock_divider)
  );
  // launch is a one-cycle pulse, so count it at every edge
  always @(posedge clk) begin
    if (cmd.launch === 1'b1) begin
      launches <= launches + 1;
      last_code <= cmd.code;
    end
    if (cmd_abort === 1'b1) aborts <= aborts + 1;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apb.penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    lerr = pslverr;
    apb <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] v;
    bus(1'b1, a, {24'h0, d}, v);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(nm, v, {24'h0, exp});
  endtask
  task automatic aw(input logic [15:0] a, input logic [7:0] d);
    arr_wr <= '{valid: 1'b1, addr: a, data: d};
    @(posedge clk);
    arr_wr <= '0;
    @(posedge clk);
  endtask
  task automatic ep(input logic t, input logic dn, input logic bo);
    eng <= '{taken: t, done: dn, blank_ok: bo};
    @(posedge clk);
    eng <= '0;
    @(posedge clk);
  endtask
  task automatic run(input logic [7:0] code, input logic [15:0] a);
    aw(a, 8'h5a);
    wr(`FSP_OFF_CMD, code);
    wr(`FSP_OFF_STAT, 8'h80);
  endtask
  task automatic do_reset(input logic [7:0] opt, input logic [7:0] prot);
    stored_option_byte <= opt;
    stored_protect_byte <= prot;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic key(input logic dbg, input logic [7:0] flip);
    wr(`FSP_OFF_CFG, 8'h20);
    background_debug_mode <= dbg;
    // flip spoils only the last byte, so the count still reaches eight
    for (int i = 0; i < 8; i++) begin
      aw(`FSP_KEY_BASE + 16'(i), stored_unlock_key[8*i +: 8] ^ ((i == 7) ? flip : 8'h00));
    end
    background_debug_mode <= 1'b0;
    wr(`FSP_OFF_CFG, 8'h00);
    @(posedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_codes();
    for (int p = 0; p < 4; p++) begin
      do_reset(8'h40 | 8'(p), 8'hff);
      chk("secure", secure, p != 2);
      rdc("option", `FSP_OFF_OPT, 8'h40 | 8'(p));
      chk("redirect_off", vector_redirect_disable, 1'b1);
      chk("backdoor", backdoor_enable, 1'b0);
    end
    rdc("status", `FSP_OFF_STAT, 8'hc0);
    rdc("prot", `FSP_OFF_PROT, 8'hff);
    rdc("div", `FSP_OFF_DIV, 8'h00);
    stored_option_byte <= 8'h80;
    rdc("option_kept", `FSP_OFF_OPT, 8'h43);
    rdc("unmapped", 8'h20, 8'h00);
    chk("pslverr", lerr, 1'b1);
    wr(`FSP_OFF_OPT, 8'hff);
    rdc("option_ro", `FSP_OFF_OPT, 8'h43);
    wr(`FSP_OFF_CFG, 8'h20);
    rdc("cfg", `FSP_OFF_CFG, 8'h20);
    wr(`FSP_OFF_CFG, 8'h00);
  endtask
  task automatic t_key();
    do_reset(8'h41, 8'hff);
    key(1'b0, 8'h00);
    chk("secure_nokey", secure, 1'b1);
    do_reset(8'h80, 8'hff);
    chk("backdoor", backdoor_enable, 1'b1);
    chk("redirect_on", vector_redirect_disable, 1'b0);
    key(1'b1, 8'h00);
    chk("secure_dbg", secure, 1'b1);
    key(1'b0, 8'h01);
    chk("secure_bad", secure, 1'b1);
    key(1'b0, 8'h00);
    chk("secure_key", secure, 1'b0);
    rdc("option_code", `FSP_OFF_OPT, 8'h82);
    rdc("status_key", `FSP_OFF_STAT, 8'hc0);
    chk("no_launch", launches, exp_l);
  endtask
  task automatic t_prot();
    do_reset(8'h03, 8'hff);
    wr(`FSP_OFF_PROT, 8'h00);
    rdc("prot_off", `FSP_OFF_PROT, 8'hff);
    background_debug_mode <= 1'b1;
    wr(`FSP_OFF_PROT, 8'h80);
    background_debug_mode <= 1'b0;
    rdc("prot_dbg", `FSP_OFF_PROT, 8'h80);
    wr(`FSP_OFF_PROT, 8'h90);
    rdc("prot_up", `FSP_OFF_PROT, 8'h80);
    wr(`FSP_OFF_PROT, 8'h60);
    rdc("prot_down", `FSP_OFF_PROT, 8'h60);
    chk("shadow", protect_shadow, 8'h60);
    wr(`FSP_OFF_DIV, 8'h0c);
    // first address past the unprotected end
    run(`FSP_CMD_PROG, 16'h6200);
    rdc("pviol", `FSP_OFF_STAT, 8'he0);
    chk("pv_launch", launches, exp_l);
    run(`FSP_CMD_PROG, 16'h61ff);
    exp_l++;
    rdc("edge_ok", `FSP_OFF_STAT, 8'h20);
    chk("edge_launch", launches, exp_l);
    ep(1'b1, 1'b1, 1'b0);
    wr(`FSP_OFF_STAT, 8'h20);
    rdc("pv_clear", `FSP_OFF_STAT, 8'hc0);
  endtask
  task automatic t_cmds();
    logic [7:0] codes [5];
    logic [31:0] v;
    codes = '{`FSP_CMD_BLANK, `FSP_CMD_PROG, `FSP_CMD_BURST, `FSP_CMD_PAGE, `FSP_CMD_MASS};
    do_reset(8'h03, 8'hff);
    run(`FSP_CMD_PROG, 16'h1000);
    rdc("no_div", `FSP_OFF_STAT, 8'hd0);
    chk("nd_launch", launches, exp_l);
    wr(`FSP_OFF_STAT, 8'h00);
    rdc("w0_keep", `FSP_OFF_STAT, 8'hd0);
    wr(`FSP_OFF_STAT, 8'h10);
    rdc("w1_clear", `FSP_OFF_STAT, 8'hc0);
    wr(`FSP_OFF_DIV, 8'h0c);
    rdc("div_ld", `FSP_OFF_DIV, 8'h8c);
    chk("div_out", nv_clock_divider, 7'h0c);
    wr(`FSP_OFF_DIV, 8'h05);
    rdc("div_once", `FSP_OFF_DIV, 8'h8c);
    run(8'h33, 16'h1000);
    rdc("illegal", `FSP_OFF_STAT, 8'hd0);
    wr(`FSP_OFF_STAT, 8'h10);
    for (int i = 0; i < 5; i++) begin
      run(codes[i], 16'h1000);
      exp_l++;
      wr(`FSP_OFF_STAT, 8'h40);
      rdc("busy", `FSP_OFF_STAT, 8'h00);
      chk("launches", launches, exp_l);
      chk("code", last_code, codes[i]);
      chk("cmd_addr", cmd.addr, 16'h1000);
      chk("cmd_data", cmd.data, 8'h5a);
      ep(1'b1, 1'b0, 1'b0);
      rdc("taken", `FSP_OFF_STAT, 8'h80);
      ep(1'b0, 1'b1, i == 0);
      rdc("done", `FSP_OFF_STAT, (i == 0) ? 8'hc4 : 8'hc0);
    end
    chk("secure_blank", secure, 1'b0);
    rdc("opt_blank", `FSP_OFF_OPT, 8'h02);
    run(`FSP_CMD_PROG, 16'h1000);
    exp_l++;
    stop_entry <= 1'b1;
    @(posedge clk);
    stop_entry <= 1'b0;
    @(posedge clk);
    bus(1'b0, `FSP_OFF_STAT, 32'h0, v);
    chk("stop_err", v & 32'h10, 32'h10);
    chk("aborts", aborts, 1);
    chk("stop_launch", launches, exp_l);
  endtask
  // ----------------------------------------
  // sequence and watchdog
  // ----------------------------------------
  initial begin
    @(posedge clk);
    t_codes();
    t_key();
    t_prot();
    t_cmds();
    summarize();
  end
  initial begin
    #(50 * 20000);
    failures++;
    summarize();
  end
endmodule
